// File: include/bccs_pkg.sv
// Shared types and constants of the bidirectional converter sequencer.
// Assumes a single 100 MHz clock and comparator flags from the analog die.
`default_nettype none
package bccs_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 10;
    localparam int EN_FILT_NS       = 2500;   // Enable glitch filter
    localparam int DIR_FILT_NS      = 10000;  // Direction glitch filter
    localparam int SD_LATCH_NS      = 2500;   // Deadtime pin low time
    localparam int LATCH_CLR_NS     = 10000;  // Enable-low time to clear
    // Least times, rounded up to whole cycles
    localparam int EN_FILT_CYC  = (EN_FILT_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
    localparam int DIR_FILT_CYC = (DIR_FILT_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
    localparam int SD_LATCH_CYC = (SD_LATCH_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
    localparam int LATCH_CLR_CYC = (LATCH_CLR_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int CNT_W        = 10;     // Holds counts up to 1023
    localparam int OSC_HALF_CYC = 50;     // Default half period, 1 MHz
    localparam int OSC_W        = 16;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BCCS_SHUTDOWN = 2'b00,
        BCCS_INIT     = 2'b01,
        BCCS_STANDBY  = 2'b10
    } bccs_mode_type;

    typedef enum logic [1:0] {
        BCCS_CH_OFF   = 2'b00,
        BCCS_CH_SOFT  = 2'b01,
        BCCS_CH_RUN   = 2'b10,
        BCCS_CH_DISCH = 2'b11
    } bccs_ch_state_type;

    localparam logic [1:0] DIR_INVALID = 2'b00;
    localparam logic [1:0] DIR_BUCK    = 2'b01;
    localparam logic [1:0] DIR_BOOST   = 2'b10;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       bias_gt_8v5;   // Bias rail above rising threshold
        logic       bias_gt_8v0;   // Bias rail above falling threshold
        logic       bias_ext;      // External 9.5 V to 12 V present
        logic       cmd_gt_1v25;   // Commander enable above 1.25 V
        logic       cmd_gt_1v5;    // Commander enable above 1.5 V
        logic       cmd_gt_2v5;    // Commander enable above 2.5 V
        logic       dtsd_gt_1v;    // Deadtime/shutdown pin above 1 V
        logic [1:0] en_gt_2v;      // Channel enable above 2 V
        logic [1:0] en_lt_1v;      // Channel enable below 1 V
        logic [1:0] dir_hi;        // Direction actively high
        logic [1:0] dir_lo;        // Direction actively low
        logic [1:0] ss_gt_0v3;     // Soft-start pin above 0.3 V
        logic [1:0] ss_gt_1v;      // Soft-start pin above 1 V
    } bccs_comp_type;

    typedef struct packed {
        logic       linear_reg_drive;
        logic       ref_reg_enable;
        logic       deadtime_shutdown_pin;  // 1.2 V pull-up enable
        logic       sync_clock_out;
        logic       latched_shutdown;
        logic [1:0] softstart_discharge;
        logic [1:0] high_side_gate;
        logic [1:0] low_side_gate;
        logic [1:0] sense_polarity;          // 1: buck polarity
    } bccs_drive_type;

    typedef struct packed {
        bccs_ch_state_type st;
        logic              buck;   // Direction the soft-start ran for
    } bccs_chan_type;

    // Three-state decode of a direction pin from its two flags
    function automatic logic [1:0] dir_decode(input logic hi,
                                              input logic lo);
        if (hi && !lo) begin
            return DIR_BUCK;
        end else if (lo && !hi) begin
            return DIR_BOOST;
        end
        return DIR_INVALID;
    endfunction

endpackage
`default_nettype wire

// File: hw/bccs_glitch_filter.sv
// Level glitch filter: accepts a new level only once the input has differed from the held level long enough.
// Assumes its input is already synchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none
module bccs_glitch_filter #(
    parameter int          W      = 1,
    parameter int          CYCLES = 250,
    parameter logic [W-1:0] INIT  = '0
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    // Level
    input  wire logic [W-1:0] i_level,
    output logic      [W-1:0] o_level
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    typedef struct packed {
        logic [W-1:0]  lvl;
        logic [CW-1:0] cnt;
    } bccs_filt_type;

    bccs_filt_type state_reg;
    bccs_filt_type state_next;

    // Any bounce back to the held level restarts the count
    always_comb begin
        state_next = state_reg;
        if (i_level == state_reg.lvl) begin
            state_next.cnt = '0;
        end else if (state_reg.cnt == LAST) begin
            state_next.lvl = i_level;
            state_next.cnt = '0;
        end else begin
            state_next.cnt = state_reg.cnt + CW'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= '{lvl: INIT, cnt: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_level = state_reg.lvl;
endmodule
`default_nettype wire

// File: hw/bccs_sequencer.sv
// Mode and command sequencer of a dual-channel bidirectional controller.
// Assumes all comparator flags arrive asynchronously from analog logic.
//
// Operation
// - Bias below 8 V holds shutdown, 8.5 V releases; here low bias only blocks standby and the mode falls to init
// - Reference regulators start only after bias is good
// - External bias supply turns linear driver off
// - Enable below 1.25 V: shutdown, gates off, reset
// - Enable 1.5-2.5 V: init, driver on, pin pull-up
// - Init keeps channels off without valid commands
// - Enable above 2.5 V starts oscillator sync clock
// - Soft-start and gates off until commanded
// - Sense polarity follows channel direction
// - Each enable governs only its own channel
// - Enable high starts channel through soft-start
// - Enable low stops gates and discharges soft-start
// - Open enable reads low via pulldown
// - Enable filter ignores pulses under 2.5 us
// - Direction high selects step-down operation
// - Direction low selects step-up operation
// - Third-state direction keeps channel in standby
// - Direction change: discharge below 0.3 V, restart
// - Direction filter ignores pulses under 10 us
// - Pin low 2.5 us latches emergency shutdown
// - Latch clears after enable low 10 us
// - Gates switch once soft-start exceeds 1 V
`timescale 1ns/1ps
`default_nettype none
module bccs_sequencer #(
    parameter int OSC_HALF = bccs_pkg::OSC_HALF_CYC
) (
    // Clock and reset
    input  wire logic                     i_clk,
    input  wire logic                     i_rst_n,
    // Comparator flags from the analog side
    input  wire bccs_pkg::bccs_comp_type  i_comp,
    // Drive and control outputs
    output bccs_pkg::bccs_drive_type      o_drive,
    output bccs_pkg::bccs_mode_type       o_mode
);
    localparam int CW = bccs_pkg::CNT_W;
    localparam int OW = bccs_pkg::OSC_W;
    localparam logic [CW-1:0] SD_LAST  = CW'(bccs_pkg::SD_LATCH_CYC - 1);
    localparam logic [CW-1:0] CLR_LAST = CW'(bccs_pkg::LATCH_CLR_CYC - 1);
    localparam logic [OW-1:0] OSC_LAST = OW'(OSC_HALF - 1);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        bccs_pkg::bccs_comp_type       s1;
        bccs_pkg::bccs_comp_type       s2;
        logic                          bias_ok;
        logic [1:0]                    en_lvl;
        bccs_pkg::bccs_mode_type       mode;
        logic                          latched;
        logic [CW-1:0]                 sd_cnt;
        logic [CW-1:0]                 clr_cnt;
        logic [OW-1:0]                 osc_cnt;
        bccs_pkg::bccs_chan_type [1:0] chan;
        bccs_pkg::bccs_drive_type      drv;
    } bccs_state_type;

    bccs_state_type state_reg;
    bccs_state_type state_next;

    logic [1:0] en_filt;
    logic [3:0] dir_filt;

    // ------------------------------------------------------------------
    // Per-channel glitch filters
    // ------------------------------------------------------------------
    // Filters sit behind the synchroniser so a bounce is seen once
    for (genvar ch = 0; ch < 2; ch++) begin : g_filt
        bccs_glitch_filter #(
            .W      (1),
            .CYCLES (bccs_pkg::EN_FILT_CYC),
            .INIT   (1'b0)
        ) u_en_filt (
            .i_clk   (i_clk),
            .i_rst_n (i_rst_n),
            .i_level (state_reg.en_lvl[ch]),
            .o_level (en_filt[ch])
        );

        bccs_glitch_filter #(
            .W      (2),
            .CYCLES (bccs_pkg::DIR_FILT_CYC),
            .INIT   (bccs_pkg::DIR_INVALID)
        ) u_dir_filt (
            .i_clk   (i_clk),
            .i_rst_n (i_rst_n),
            .i_level (bccs_pkg::dir_decode(state_reg.s2.dir_hi[ch],
                                           state_reg.s2.dir_lo[ch])),
            .o_level (dir_filt[2*ch +: 2])
        );
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic       run_ok;
        logic       req;
        logic       buck;
        logic [1:0] dir;
        run_ok = 1'b0;
        req    = 1'b0;
        buck   = 1'b0;
        dir    = bccs_pkg::DIR_INVALID;
        state_next = state_reg;

        // Two-flop synchroniser on every comparator flag
        state_next.s1 = i_comp;
        state_next.s2 = state_reg.s1;

        // Bias hysteresis between the two thresholds
        if (state_reg.s2.bias_gt_8v5) begin
            state_next.bias_ok = 1'b1;
        end else if (!state_reg.s2.bias_gt_8v0) begin
            state_next.bias_ok = 1'b0;
        end

        // Enable hysteresis; an open pin reads below 1 V
        for (int ch = 0; ch < 2; ch++) begin
            if (state_reg.s2.en_gt_2v[ch]) begin
                state_next.en_lvl[ch] = 1'b1;
            end else if (state_reg.s2.en_lt_1v[ch]
                         || !state_reg.s2.en_gt_2v[ch]
                            && !state_reg.s2.en_lt_1v[ch]
                            && 1'b0) begin
                state_next.en_lvl[ch] = 1'b0;
            end
        end

        // Operating mode from the commander enable levels
        if (!state_reg.s2.cmd_gt_1v25) begin
            state_next.mode = bccs_pkg::BCCS_SHUTDOWN;
        end else if (state_reg.s2.cmd_gt_2v5 && state_reg.bias_ok) begin
            state_next.mode = bccs_pkg::BCCS_STANDBY;
        end else if (state_reg.s2.cmd_gt_1v5
                     || state_reg.mode != bccs_pkg::BCCS_SHUTDOWN) begin
            state_next.mode = bccs_pkg::BCCS_INIT;
        end

        // Emergency latch: set by a long low on the deadtime pin
        if (!state_reg.s2.dtsd_gt_1v
            && state_reg.mode == bccs_pkg::BCCS_STANDBY) begin
            if (state_reg.sd_cnt == SD_LAST) begin
                state_next.latched = 1'b1;
            end else begin
                state_next.sd_cnt = state_reg.sd_cnt + CW'(1);
            end
        end else begin
            state_next.sd_cnt = '0;
        end
        // Only a long enable low clears it; a short dip does not
        if (!state_reg.s2.cmd_gt_1v25) begin
            if (state_reg.clr_cnt == CLR_LAST) begin
                state_next.latched = 1'b0;
            end else begin
                state_next.clr_cnt = state_reg.clr_cnt + CW'(1);
            end
        end else begin
            state_next.clr_cnt = '0;
        end

        run_ok = state_reg.mode == bccs_pkg::BCCS_STANDBY
                 && state_reg.bias_ok && !state_reg.latched;

        // Channel sequencing, each channel on its own commands
        for (int ch = 0; ch < 2; ch++) begin
            dir  = dir_filt[2*ch +: 2];
            buck = (dir == bccs_pkg::DIR_BUCK);
            req  = run_ok && en_filt[ch]
                   && dir != bccs_pkg::DIR_INVALID;
            unique case (state_reg.chan[ch].st)
                bccs_pkg::BCCS_CH_OFF: begin
                    if (req) begin
                        state_next.chan[ch].st   = bccs_pkg::BCCS_CH_SOFT;
                        state_next.chan[ch].buck = buck;
                    end
                end
                bccs_pkg::BCCS_CH_SOFT,
                bccs_pkg::BCCS_CH_RUN: begin
                    if (!req) begin
                        state_next.chan[ch].st = bccs_pkg::BCCS_CH_OFF;
                    end else if (buck != state_reg.chan[ch].buck) begin
                        state_next.chan[ch].st = bccs_pkg::BCCS_CH_DISCH;
                    end else if (state_reg.s2.ss_gt_1v[ch]) begin
                        state_next.chan[ch].st = bccs_pkg::BCCS_CH_RUN;
                    end
                end
                bccs_pkg::BCCS_CH_DISCH: begin
                    if (!req) begin
                        state_next.chan[ch].st = bccs_pkg::BCCS_CH_OFF;
                    end else if (!state_reg.s2.ss_gt_0v3[ch]) begin
                        state_next.chan[ch].st   = bccs_pkg::BCCS_CH_SOFT;
                        state_next.chan[ch].buck = buck;
                    end
                end
            endcase
            // Shutdown clears all channel logic at once
            if (state_reg.mode == bccs_pkg::BCCS_SHUTDOWN) begin
                state_next.chan[ch].st   = bccs_pkg::BCCS_CH_OFF;
                state_next.chan[ch].buck = 1'b0;
            end
        end

        // Oscillator runs only once fully enabled
        if (state_reg.mode == bccs_pkg::BCCS_STANDBY) begin
            if (state_reg.osc_cnt == OSC_LAST) begin
                state_next.osc_cnt = '0;
                state_next.drv.sync_clock_out =
                    !state_reg.drv.sync_clock_out;
            end else begin
                state_next.osc_cnt = state_reg.osc_cnt + OW'(1);
            end
        end else begin
            state_next.osc_cnt            = '0;
            state_next.drv.sync_clock_out = 1'b0;
        end

        // Registered drive outputs, derived from the present state
        state_next.drv.linear_reg_drive =
            state_reg.mode != bccs_pkg::BCCS_SHUTDOWN
            && !state_reg.s2.bias_ext;
        state_next.drv.ref_reg_enable =
            state_reg.mode != bccs_pkg::BCCS_SHUTDOWN
            && state_reg.bias_ok;
        state_next.drv.deadtime_shutdown_pin =
            state_reg.mode != bccs_pkg::BCCS_SHUTDOWN;
        state_next.drv.latched_shutdown = state_reg.latched;
        for (int ch = 0; ch < 2; ch++) begin
            // Gates only in run; a latch, low bias or lost standby stops them now
            state_next.drv.high_side_gate[ch] =
                state_reg.chan[ch].st == bccs_pkg::BCCS_CH_RUN
                && run_ok;
            state_next.drv.low_side_gate[ch] =
                state_next.drv.high_side_gate[ch];
            state_next.drv.softstart_discharge[ch] =
                state_reg.chan[ch].st == bccs_pkg::BCCS_CH_OFF
                || state_reg.chan[ch].st == bccs_pkg::BCCS_CH_DISCH
                || !run_ok;
            state_next.drv.sense_polarity[ch] =
                state_reg.chan[ch].buck;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // The latch has its own clear path, so reset only zeroes it at power
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= '0;
            state_reg.drv.softstart_discharge <= 2'b11;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_drive = state_reg.drv;
    assign o_mode  = state_reg.mode;
endmodule
`default_nettype wire

// File: tb/bccs_sequencer_monitor.sv
// Concurrent checks on the ports of the command sequencer.
// Assumes one clock domain; bound onto every sequencer instance.
`timescale 1ns/1ps
`default_nettype none
module bccs_sequencer_monitor #(
    parameter int OSC_HALF = bccs_pkg::OSC_HALF_CYC
) (
    // Clock and reset
    input wire logic                     i_clk,
    input wire logic                     i_rst_n,
    // Watched ports
    input wire bccs_pkg::bccs_comp_type  i_comp,
    input wire bccs_pkg::bccs_drive_type o_drive,
    input wire bccs_pkg::bccs_mode_type  o_mode
);
    // ------------------------------------------------------------------
    // Sync clock half-period counter
    // ------------------------------------------------------------------
    logic [15:0] half_reg;
    logic [1:0]  tog_reg;
    logic        sync_reg;
    logic        chg;
    logic        stby;

    assign chg  = o_drive.sync_clock_out != sync_reg;
    assign stby = o_mode == bccs_pkg::BCCS_STANDBY;

    // First edge in standby starts mid-phase, so only later ones count
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            half_reg <= 16'h0000;
            tog_reg  <= 2'b00;
            sync_reg <= 1'b0;
        end else begin
            sync_reg <= o_drive.sync_clock_out;
            half_reg <= chg ? 16'h0000 : half_reg + 16'h0001;
            if (!stby) begin
                tog_reg <= 2'b00;
            end else if (chg && tog_reg != 2'b11) begin
                tog_reg <= tog_reg + 2'b01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    shut_gates_a: assert property ((!i_comp.cmd_gt_1v25) [*6] |->
        o_mode == bccs_pkg::BCCS_SHUTDOWN && o_drive.high_side_gate == 2'b00)
        else $error("gates on or mode wrong with enable low");
    init_drive_a: assert property ((i_comp.cmd_gt_1v25 && i_comp.cmd_gt_1v5
        && !i_comp.cmd_gt_2v5 && !i_comp.bias_ext) [*6] |-> o_mode ==
        bccs_pkg::BCCS_INIT && o_drive.linear_reg_drive
        && o_drive.deadtime_shutdown_pin) else $error("init outputs wrong");
    ext_bias_a: assert property (i_comp.bias_ext [*6] |->
        !o_drive.linear_reg_drive) else $error("linear driver on");
    bias_low_a: assert property ((!i_comp.bias_gt_8v0
        && !i_comp.bias_gt_8v5) [*6] |-> !stby && !o_drive.ref_reg_enable)
        else $error("standby or reference with low bias");
    gate_pair_a: assert property (o_drive.high_side_gate ==
        o_drive.low_side_gate) else $error("gate pair differs");
    gate_mode_a: assert property (o_drive.high_side_gate != 2'b00 |->
        $past(o_mode) == bccs_pkg::BCCS_STANDBY)
        else $error("gates on outside standby");
    gate_disch_a: assert property ((o_drive.high_side_gate &
        o_drive.softstart_discharge) == 2'b00)
        else $error("gate on while soft-start discharged");
    latch_hold_a: assert property (o_drive.latched_shutdown &&
        $past(o_drive.latched_shutdown) |-> o_drive.high_side_gate == 2'b00
        && o_drive.softstart_discharge == 2'b11)
        else $error("latched shutdown not holding outputs");
    sync_still_a: assert property ((!stby) [*3] |->
        $stable(o_drive.sync_clock_out)) else $error("sync runs off standby");
    sync_half_a: assert property (chg && tog_reg != 2'b00 && stby
        && !o_drive.latched_shutdown |-> half_reg == 16'(OSC_HALF - 1))
        else $error("sync half period wrong");

    cover property (o_drive.latched_shutdown);
    cover property (o_drive.high_side_gate[0] && o_drive.sense_polarity[0]);
    cover property (o_drive.high_side_gate[1] && !o_drive.sense_polarity[1]);
endmodule

bind bccs_sequencer bccs_sequencer_monitor #(.OSC_HALF(OSC_HALF))
    i_bccs_sequencer_monitor (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_comp(i_comp), .o_drive(o_drive), .o_mode(o_mode));
`default_nettype wire

// File: tb/bccs_host_model.sv
// Host controller pins seen through the device's input comparators.
// Assumes the bench sets pin states off the clock's rising edge.
`timescale 1ns/1ps
`default_nettype none
module bccs_host_model (
    // Pin states, two bits a channel
    input  wire logic [3:0] i_en_pin,   // 00 low, 01 high, 10 open
    input  wire logic [3:0] i_dir_pin,  // 00 low, 01 high, 10 float, 11 bad
    // Comparator flags
    output logic      [1:0] o_en_gt_2v,
    output logic      [1:0] o_en_lt_1v,
    output logic      [1:0] o_dir_hi,
    output logic      [1:0] o_dir_lo
);
    // Open enable reads low through the pulldown; a float shows no flag
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            o_en_gt_2v[c] = i_en_pin[2*c +: 2] == 2'b01;
            o_en_lt_1v[c] = i_en_pin[2*c +: 2] != 2'b01;
            o_dir_hi[c]   = i_dir_pin[2*c] == 1'b1;
            o_dir_lo[c]   = i_dir_pin[2*c +: 2] inside {2'b00, 2'b11};
        end
    end
endmodule
`default_nettype wire

// File: tb/bccs_sequencer_test.sv
// Self-checking bench of the command sequencer with a host model.
// Assumes 100 MHz clock; soft-start pins are modelled as ramps here.
`timescale 1ns/1ps
`default_nettype none
module bccs_sequencer_test;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam int OSC_H = 3;
    localparam int EF    = bccs_pkg::EN_FILT_CYC + 12;
    localparam int DF    = bccs_pkg::DIR_FILT_CYC + 12;
    logic                     clk, rst_n, b85, b80, bext, c125, c15, c25;
    logic                     dtsd, lvl;
    logic [1:0]               en_hi, en_lo, dir_hi, dir_lo, ss03, ss1;
    logic [3:0]               en_pin, dir_pin;
    bccs_pkg::bccs_comp_type  comp;
    bccs_pkg::bccs_drive_type drv;
    bccs_pkg::bccs_mode_type  mode;
    int                       errors, cmp_count, k;
    int                       ss_v[2] = '{0, 0};
    int                       exp_on[2], exp_pol[2];
    int unsigned              seed;

    assign comp = {b85, b80, bext, c125, c15, c25, dtsd, en_hi, en_lo,
                   dir_hi, dir_lo, ss03, ss1};
    assign ss03 = {ss_v[1] > 3, ss_v[0] > 3};
    assign ss1  = {ss_v[1] > 40, ss_v[0] > 40};

    bccs_sequencer #(.OSC_HALF(OSC_H)) i_bccs_sequencer (.i_clk(clk),
        .i_rst_n(rst_n), .i_comp(comp), .o_drive(drv), .o_mode(mode));
    bccs_host_model i_bccs_host_model (.i_en_pin(en_pin),
        .i_dir_pin(dir_pin), .o_en_gt_2v(en_hi), .o_en_lt_1v(en_lo),
        .o_dir_hi(dir_hi), .o_dir_lo(dir_lo));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Soft-start capacitor: slow rise, fast pull-down while discharged
    always @(negedge clk) begin
        for (int c = 0; c < 2; c++) begin
            if (drv.softstart_discharge[c] !== 1'b0) begin
                ss_v[c] = (ss_v[c] > 4) ? ss_v[c] - 4 : 0;
            end else if (ss_v[c] < 60) begin
                ss_v[c] = ss_v[c] + 1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Compare both channels with the expected channel model
    task automatic chk_chans();
        for (int c = 0; c < 2; c++) begin
            check("high_gate", 16'(drv.high_side_gate[c]), 16'(exp_on[c]));
            check("low_gate", 16'(drv.low_side_gate[c]), 16'(exp_on[c]));
            check("ss_disch", 16'(drv.softstart_discharge[c]),
                  16'(exp_on[c] == 0));
            if (exp_on[c] != 0) begin
                check("polarity", 16'(drv.sense_polarity[c]),
                      16'(exp_pol[c]));
            end
        end
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // A hang would stall the sequence; the run needs about 11k cycles
    initial begin
        #500_000;
        errors++;
        stop_test();
    end

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        seed = $urandom(32'h0000_a925);
        rst_n = 1'b0;
        {b85, b80, bext, c125, c15, c25} = 6'b00_0000;
        dtsd = 1'b1;
        en_pin = 4'b1010;
        dir_pin = 4'b1010;
        exp_on = '{0, 0};
        exp_pol = '{0, 0};
        cyc(6);
        rst_n = 1'b1;
        cyc(1);
        check("mode", 16'(mode), 16'(bccs_pkg::BCCS_SHUTDOWN));
        chk_chans();
        {c125, c15} = 2'b11;
        en_pin = 4'b0101;
        dir_pin = 4'b0101;
        cyc(DF);
        check("mode", 16'(mode), 16'(bccs_pkg::BCCS_INIT));
        check("lin_drive", 16'(drv.linear_reg_drive), 16'h0001);
        check("dt_pullup", 16'(drv.deadtime_shutdown_pin), 16'h0001);
        check("ref_reg", 16'(drv.ref_reg_enable), 16'h0000);
        chk_chans();
        en_pin = 4'b1010;
        dir_pin = 4'b1010;
        cyc(DF);
        c25 = 1'b1;
        cyc(10);
        check("mode", 16'(mode), 16'(bccs_pkg::BCCS_INIT));
        {b85, b80} = 2'b11;
        cyc(10);
        check("mode", 16'(mode), 16'(bccs_pkg::BCCS_STANDBY));
        check("ref_reg", 16'(drv.ref_reg_enable), 16'h0001);
        bext = 1'b1;
        cyc(10);
        check("lin_drive", 16'(drv.linear_reg_drive), 16'h0000);
        repeat (2) begin
            k = 0;
            lvl = drv.sync_clock_out;
            while (drv.sync_clock_out === lvl && k < 50) begin
                cyc(1);
                k++;
            end
        end
        check("sync_half", 16'(k), 16'(OSC_H));
        en_pin = 4'b0101;
        dir_pin = 4'b1011;
        cyc(DF + 60);
        chk_chans();
        dir_pin = 4'b1001;
        cyc(DF);
        check("ss_disch0", 16'(drv.softstart_discharge[0]), 16'h0000);
        check("high_gate0", 16'(drv.high_side_gate[0]), 16'h0000);
        exp_on[0] = 1;
        exp_pol[0] = 1;
        cyc(80);
        chk_chans();
        dir_pin[1:0] = 2'b00;
        cyc(300 + int'($urandom % 500));
        dir_pin[1:0] = 2'b01;
        cyc(DF);
        chk_chans();
        en_pin[3:2] = 2'b00;
        dir_pin[3:2] = 2'b00;
        cyc(DF);
        chk_chans();
        en_pin[3:2] = 2'b01;
        cyc(20 + int'($urandom % 200));
        en_pin[3:2] = 2'b00;
        cyc(EF + 80);
        chk_chans();
        en_pin[3:2] = 2'b01;
        exp_on[1] = 1;
        cyc(EF + 80);
        chk_chans();
        dir_pin[1:0] = 2'b00;
        exp_on[0] = 0;
        cyc(DF);
        chk_chans();
        exp_on[0] = 1;
        exp_pol[0] = 0;
        cyc(80);
        chk_chans();
        en_pin[1:0] = 2'b10;
        exp_on[0] = 0;
        cyc(EF);
        chk_chans();
        dtsd = 1'b0;
        cyc(20 + int'($urandom % 200));
        dtsd = 1'b1;
        cyc(10);
        check("latched", 16'(drv.latched_shutdown), 16'h0000);
        dtsd = 1'b0;
        cyc(300);
        dtsd = 1'b1;
        cyc(10);
        exp_on[1] = 0;
        check("latched", 16'(drv.latched_shutdown), 16'h0001);
        chk_chans();
        {c125, c15, c25} = 3'b000;
        cyc(500);
        {c125, c15, c25} = 3'b111;
        cyc(10);
        check("latched", 16'(drv.latched_shutdown), 16'h0001);
        {c125, c15, c25} = 3'b000;
        cyc(1100);
        check("latched", 16'(drv.latched_shutdown), 16'h0000);
        check("mode", 16'(mode), 16'(bccs_pkg::BCCS_SHUTDOWN));
        {c125, c15, c25} = 3'b111;
        cyc(10);
        {b85, b80} = 2'b00;
        cyc(10);
        check("mode", 16'(mode), 16'(bccs_pkg::BCCS_INIT));
        chk_chans();
        stop_test();
    end
endmodule
`default_nettype wire
